// ==== mulu_logic_store_exec.sv ====
`timescale 1ns/1ps
module mulu_logic_store_exec
  import mulu_logic_store_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              instrValid,
  input  wire logic [31:0]       instrWord,
  input  wire logic [XLEN-1:0]   firstSourceVal,
  input  wire logic [XLEN-1:0]   secondSourceVal,
  input  wire logic              mode64,
  input  wire logic              userOrSupervisor,
  input  wire logic              cpuBigEndianFlag,
  input  wire logic              userEndianSwapFlag,
  input  wire logic              xlatRefill,
  input  wire logic              xlatInvalid,
  input  wire logic              xlatModify,
  input  wire logic              busError,
  output logic                   destWrite,
  output logic [4:0]             destIndex,
  output logic [XLEN-1:0]        destData,
  output logic                   memWrite,
  output logic [XLEN-1:0]        memAddr,
  output logic [XLEN-1:0]        memData,
  output logic [7:0]             memByteEnable,
  output logic [2:0]             memPhysLaneXor,
  output logic                   excValid,
  output logic [4:0]             excCode,
  output logic                   busErrorReport,
  output logic                   mulBusy,
  output logic                   mulDone,
  output logic [XLEN-1:0]        upperProductReg,
  output logic [XLEN-1:0]        bottomProductReg
);
  logic [5:0]      opcode;
  logic [5:0]      funct;
  logic [4:0]      srcT;
  logic [4:0]      dstD;
  logic [15:0]     imm;
  logic [XLEN-1:0] effAddr;
  logic [2:0]      lane;
  logic            isSpecial;
  logic            mulStart;

  logic            next_destWrite;
  logic [4:0]      next_destIndex;
  logic [XLEN-1:0] next_destData;
  logic            next_memWrite;
  logic [XLEN-1:0] next_memAddr;
  logic [XLEN-1:0] next_memData;
  logic [7:0]      next_memByteEnable;
  logic [2:0]      next_memPhysLaneXor;
  logic            next_excValid;
  logic [4:0]      next_excCode;
  logic            next_busErrorReport;

  assign opcode    = instrWord[31:26];
  assign funct     = instrWord[5:0];
  assign srcT      = instrWord[20:16];
  assign dstD      = instrWord[15:11];
  assign imm       = instrWord[15:0];
  assign isSpecial = (opcode == OPC_SPECIAL);
  // Base plus sign-extended offset
  assign effAddr   = firstSourceVal + {{(XLEN-16){imm[15]}}, imm};
  // Lane flipped for big-endian core
  assign lane      = effAddr[2:0] ^ {3{cpuBigEndianFlag}};
  // Back-to-back starts while busy are dropped; software spacing covers it
  assign mulStart  = instrValid && isSpecial && (funct == FN_UNSIGNED_MULTIPLY) && !mulBusy;

  product_unit u_product (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .start         (mulStart),
    .mode64        (mode64),
    .opA           (firstSourceVal),
    .opB           (secondSourceVal),
    .busy          (mulBusy),
    .done          (mulDone),
    .upperProduct  (upperProductReg),
    .bottomProduct (bottomProductReg)
  );

  always_comb begin
    next_destWrite      = 1'b0;
    next_destIndex      = 5'h00;
    next_destData       = '0;
    next_memWrite       = 1'b0;
    next_memAddr        = memAddr;
    next_memData        = memData;
    next_memByteEnable  = 8'h00;
    next_memPhysLaneXor = 3'h0;
    next_excValid       = 1'b0;
    next_excCode        = EXC_NONE;
    // Translation faults come back the cycle a store is issued
    next_busErrorReport = 1'b0;
    if (instrValid) begin
      if (isSpecial && funct == FN_NOR) begin
        next_destWrite = 1'b1;
        next_destIndex = dstD;
        next_destData  = ~(firstSourceVal | secondSourceVal);
      end else if (isSpecial && funct == FN_OR) begin
        next_destWrite = 1'b1;
        next_destIndex = dstD;
        next_destData  = firstSourceVal | secondSourceVal;
      end else if (opcode == OPC_ORI) begin
        next_destWrite = 1'b1;
        next_destIndex = srcT;
        next_destData  = firstSourceVal | {{(XLEN-16){1'b0}}, imm};
      end else if (opcode == OPC_SB || opcode == OPC_SD) begin
        next_memAddr        = effAddr;
        next_memPhysLaneXor = {3{userEndianSwapFlag}};
        if (opcode == OPC_SD && !mode64 && userOrSupervisor) begin
          next_excValid = 1'b1;
          next_excCode  = EXC_RESV;
        end else if (opcode == OPC_SD && effAddr[2:0] != 3'h0) begin
          next_excValid = 1'b1;
          next_excCode  = EXC_ADDR;
        end else if (xlatRefill || xlatInvalid || xlatModify) begin
          next_excValid = 1'b1;
          next_excCode  = xlatRefill ? EXC_TLB_REFILL : (xlatInvalid ? EXC_TLB_INVALID : EXC_TLB_MOD);
        end else begin
          next_memWrite = 1'b1;
          if (opcode == OPC_SB) begin
            next_memData       = secondSourceVal << {lane, 3'b000};
            next_memByteEnable = BYTE_MASK_ONE << lane;
          end else begin
            next_memData       = secondSourceVal;
            next_memByteEnable = BYTE_MASK_ALL;
          end
        end
      end
    end
    // Bus error arrives after the write went out; reported on its own
    if (busError) begin
      next_busErrorReport = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      destWrite      <= 1'b0;
      destIndex      <= 5'h00;
      destData       <= '0;
      memWrite       <= 1'b0;
      memAddr        <= '0;
      memData        <= '0;
      memByteEnable  <= 8'h00;
      memPhysLaneXor <= 3'h0;
      excValid       <= 1'b0;
      excCode        <= EXC_NONE;
      busErrorReport <= 1'b0;
    end else begin
      destWrite      <= next_destWrite;
      destIndex      <= next_destIndex;
      destData       <= next_destData;
      memWrite       <= next_memWrite;
      memAddr        <= next_memAddr;
      memData        <= next_memData;
      memByteEnable  <= next_memByteEnable;
      memPhysLaneXor <= next_memPhysLaneXor;
      excValid       <= next_excValid;
      excCode        <= next_excCode;
      busErrorReport <= next_busErrorReport;
    end
  end
endmodule

// ==== mulu_logic_store_monitor.sv ====
`timescale 1ns/1ps
module mulu_logic_store_monitor
  import mulu_logic_store_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            nrst,
  input wire logic            instrValid,
  input wire logic [31:0]     instrWord,
  input wire logic [XLEN-1:0] firstSourceVal,
  input wire logic [XLEN-1:0] secondSourceVal,
  input wire logic            mode64,
  input wire logic            userOrSupervisor,
  input wire logic            cpuBigEndianFlag,
  input wire logic            xlatRefill,
  input wire logic            xlatInvalid,
  input wire logic            xlatModify,
  input wire logic            destWrite,
  input wire logic [XLEN-1:0] destData,
  input wire logic            memWrite,
  input wire logic [XLEN-1:0] memAddr,
  input wire logic [7:0]      memByteEnable,
  input wire logic            excValid,
  input wire logic [4:0]      excCode,
  input wire logic            mulBusy,
  input wire logic            mulDone
);
  logic [XLEN-1:0] va;
  logic [2:0]      lane;
  logic            rOp, isMul, isSb, isSd, noFault;
  assign va = firstSourceVal + {{48{instrWord[15]}}, instrWord[15:0]};
  assign lane = va[2:0] ^ {3{cpuBigEndianFlag}};
  assign rOp = instrValid && instrWord[31:26] == OPC_SPECIAL;
  // Busy multiplier ignores a new start, so it is not a cause
  assign isMul = rOp && instrWord[5:0] == FN_UNSIGNED_MULTIPLY && !mulBusy;
  assign isSb = instrValid && instrWord[31:26] == OPC_SB;
  assign isSd = instrValid && instrWord[31:26] == OPC_SD;
  assign noFault = !(xlatRefill || xlatInvalid || xlatModify);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence mulRun;
    mulBusy [*3] ##1 mulDone;
  endsequence
  AST_MUL_LAT: assert property (isMul |=> mulRun and !excValid) else $error("multiply timing");
  AST_OR: assert property (rOp && instrWord[5:0] == FN_OR |=> destWrite && !excValid
    && destData == ($past(firstSourceVal) | $past(secondSourceVal))) else $error("or result");
  AST_NOR: assert property (rOp && instrWord[5:0] == FN_NOR |=> destWrite
    && destData == ~($past(firstSourceVal) | $past(secondSourceVal))) else $error("nor result");
  AST_ORI: assert property (instrValid && instrWord[31:26] == OPC_ORI |=> destWrite
    && destData == {$past(firstSourceVal[63:16]), $past(firstSourceVal[15:0] | instrWord[15:0])})
    else $error("immediate or result");
  AST_SB: assert property (isSb && noFault |=> memWrite && memAddr == $past(va)
    && memByteEnable == BYTE_MASK_ONE << $past(lane)) else $error("byte store");
  AST_SD_WR: assert property (isSd && mode64 && va[2:0] == 3'h0 && noFault |=> memWrite
    && memAddr == $past(va) && memByteEnable == BYTE_MASK_ALL) else $error("doubleword store");
  AST_SD_ALIGN: assert property (isSd && mode64 && va[2:0] != 3'h0 |=> excValid
    && excCode == EXC_ADDR && !memWrite) else $error("misaligned store");
  AST_SD_RESV: assert property (isSd && !mode64 && userOrSupervisor |=> excValid
    && excCode == EXC_RESV && !memWrite) else $error("reserved store");
endmodule
bind mulu_logic_store_exec mulu_logic_store_monitor i_mon (.*);

// ==== mulu_logic_store_pkg.sv ====
package mulu_logic_store_pkg;
  localparam int XLEN = 64;
  localparam int HALF = 32;
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] OPC_ORI = 6'h0d;
  localparam logic [5:0] OPC_SB = 6'h28;
  localparam logic [5:0] OPC_SD = 6'h3f;
  localparam logic [5:0] FN_UNSIGNED_MULTIPLY = 6'h19;
  localparam logic [5:0] FN_OR = 6'h25;
  localparam logic [5:0] FN_NOR = 6'h27;
  localparam int MUL_LATENCY = 3;
  localparam logic [1:0] MUL_CNT_INIT = 2'h2;
  localparam logic [7:0] BYTE_MASK_ONE = 8'h01;
  localparam logic [7:0] BYTE_MASK_ALL = 8'hff;
  localparam logic [63:0] PRODUCT_RESET = 64'h0;
  localparam logic [4:0] EXC_NONE = 5'h00;
  localparam logic [4:0] EXC_ADDR = 5'h01;
  localparam logic [4:0] EXC_RESV = 5'h02;
  localparam logic [4:0] EXC_TLB_REFILL = 5'h04;
  localparam logic [4:0] EXC_TLB_INVALID = 5'h08;
  localparam logic [4:0] EXC_TLB_MOD = 5'h10;
  typedef enum logic [1:0] {MUL_IDLE = 2'b00, MUL_BUSY = 2'b01, MUL_DONE = 2'b11} mul_state_t;
endpackage

// ==== product_unit.sv ====
`timescale 1ns/1ps
module product_unit
  import mulu_logic_store_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              start,
  input  wire logic              mode64,
  input  wire logic [XLEN-1:0]   opA,
  input  wire logic [XLEN-1:0]   opB,
  output logic                   busy,
  output logic                   done,
  output logic [XLEN-1:0]        upperProduct,
  output logic [XLEN-1:0]        bottomProduct
);
  mul_state_t state;
  mul_state_t next_state;
  logic [1:0]  cnt;
  logic [1:0]  next_cnt;
  logic [63:0] prod;
  logic [63:0] next_prod;
  logic [XLEN-1:0] next_upper;
  logic [XLEN-1:0] next_bottom;
  logic        is64;
  logic        next_is64;

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_prod   = prod;
    next_is64   = is64;
    next_upper  = upperProduct;
    next_bottom = bottomProduct;
    case (state)
      MUL_IDLE: begin
        if (start) begin
          // Only low halves used, zero-extended: unsigned
          next_prod  = {32'h0, opA[HALF-1:0]} * {32'h0, opB[HALF-1:0]};
          next_is64  = mode64;
          next_cnt   = MUL_CNT_INIT;
          next_state = MUL_BUSY;
        end
      end
      MUL_BUSY: begin
        // Product regs undefined for two cycles; old value simply held
        next_cnt = cnt - 2'h1;
        if (cnt == 2'h1) begin
          next_state = MUL_DONE;
        end
      end
      MUL_DONE: begin
        // No overflow path exists at all
        next_bottom = is64 ? {{HALF{prod[31]}}, prod[31:0]} : {32'h0, prod[31:0]};
        next_upper  = is64 ? {{HALF{prod[63]}}, prod[63:32]} : {32'h0, prod[63:32]};
        next_state  = MUL_IDLE;
      end
      default: next_state = MUL_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state         <= MUL_IDLE;
      cnt           <= 2'h0;
      prod          <= PRODUCT_RESET;
      is64          <= 1'b0;
      upperProduct  <= PRODUCT_RESET;
      bottomProduct <= PRODUCT_RESET;
      busy          <= 1'b0;
      done          <= 1'b0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      prod          <= next_prod;
      is64          <= next_is64;
      upperProduct  <= next_upper;
      bottomProduct <= next_bottom;
      busy          <= (next_state != MUL_IDLE);
      done          <= (state == MUL_DONE);
    end
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import mulu_logic_store_pkg::*;
  logic            core_clk, nrst, instrValid, mode64, userOrSupervisor, cpuBigEndianFlag, userEndianSwapFlag;
  logic            busError, xlatRefill, xlatInvalid, xlatModify, destWrite, memWrite, excValid;
  logic            busErrorReport, mulBusy, mulDone;
  logic [31:0]     instrWord;
  logic [4:0]      destIndex, excCode;
  logic [7:0]      memByteEnable;
  logic [2:0]      memPhysLaneXor, faultSel;
  logic [XLEN-1:0] firstSourceVal, secondSourceVal, destData, memAddr, memData, upperProductReg, bottomProductReg;
  int              fail_count, n_tests, cyc;
  mulu_logic_store_exec i_mulu_logic_store_exec (.*);
  xlat_mem_model i_xlat_mem_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      report_and_stop;
    end
  end
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task step;
    @(posedge core_clk);
    #1;
  endtask
  task idle;
    instrValid = 1'b0;
    step;
  endtask
  // Valid stays high between issues, so back-to-back is exercised
  task issue(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
    instrWord = w;
    firstSourceVal = a;
    secondSourceVal = b;
    instrValid = 1'b1;
    step;
  endtask
  function automatic logic [63:0] sx(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction
  task automatic store(input logic [5:0] opc, input logic [63:0] a, input logic [15:0] off, input logic [4:0] ec);
    logic [63:0] va, b;
    logic [2:0]  ln;
    b = {$urandom, $urandom};
    va = a + {{48{off[15]}}, off};
    ln = va[2:0] ^ {3{cpuBigEndianFlag}};
    issue({opc, 10'h22, off}, a, b);
    chk(excValid, ec != 5'h0);
    chk(memWrite, ec == 5'h0);
    if (ec == 5'h0) begin
      chk(memAddr, va);
      chk(memData, opc == OPC_SB ? b << (8 * ln) : b);
      chk(memByteEnable, opc == OPC_SB ? 8'h01 << ln : 8'hff);
      chk(memPhysLaneXor, {3{userEndianSwapFlag}});
    end else chk(excCode, ec);
  endtask
  initial begin
    logic [63:0] a, b, t;
    logic [15:0] im;
    logic [4:0]  rd;
    int          k;
    {nrst, instrValid, instrWord, firstSourceVal, secondSourceVal, faultSel} = '0;
    {mode64, userOrSupervisor, cpuBigEndianFlag, userEndianSwapFlag} = 4'hc;
    void'($urandom(98264));
    repeat (5) @(posedge core_clk);
    #1 nrst = 1'b1;
    for (k = 0; k < 30; k++) begin
      a = {$urandom, $urandom};
      b = {$urandom, $urandom};
      im = 16'($urandom);
      rd = 5'($urandom);
      mode64 = k[0];
      case (k % 3)
        0: issue({OPC_SPECIAL, 10'h0, rd, 5'h0, FN_OR}, a, b);
        1: issue({OPC_SPECIAL, 10'h0, rd, 5'h0, FN_NOR}, a, b);
        default: issue({OPC_ORI, 5'h0, rd, im}, a, b);
      endcase
      chk(destWrite, 1'b1);
      chk(destIndex, rd);
      chk(excValid, 1'b0);
      chk(destData, k % 3 == 0 ? a | b : k % 3 == 1 ? ~(a | b) : {a[63:16], a[15:0] | im});
    end
    $display("logic test done");
    for (k = 0; k < 12; k++) begin
      mode64 = k[0];
      a = k < 2 ? '1 : sx($urandom);
      b = k < 2 ? '1 : sx($urandom);
      t = {32'h0, a[31:0]} * {32'h0, b[31:0]};
      issue({OPC_SPECIAL, 10'h22, 10'h0, FN_UNSIGNED_MULTIPLY}, a, b);
      chk(mulBusy, 1'b1);
      chk(excValid, 1'b0);
      issue({OPC_SPECIAL, 10'h22, 10'h0, FN_UNSIGNED_MULTIPLY}, b, 64'h0);
      idle;
      idle;
      chk(mulDone, 1'b1);
      chk(bottomProductReg, mode64 ? sx(t[31:0]) : {32'h0, t[31:0]});
      chk(upperProductReg, mode64 ? sx(t[63:32]) : {32'h0, t[63:32]});
    end
    $display("multiply test done");
    for (k = 0; k < 32; k++) begin
      a = {$urandom, $urandom};
      im = 16'($urandom);
      cpuBigEndianFlag = k[3];
      userEndianSwapFlag = k[1];
      mode64 = k % 8 != 4;
      faultSel = k % 8 > 4 ? 3'(k % 8 - 4) : 3'h0;
      case (k % 8)
        2: store(OPC_SD, a & ~64'h7, {im[15:3], 3'h0}, 5'h0);
        3: store(OPC_SD, a & ~64'h7, {im[15:3], 3'h5}, EXC_ADDR);
        4: store(OPC_SD, a, im, EXC_RESV);
        5, 6, 7: store(OPC_SB, a, im, 5'h1 << (k % 8 - 3));
        default: store(OPC_SB, a, im, 5'h0);
      endcase
    end
    faultSel = 3'h4;
    idle;
    faultSel = 3'h0;
    chk(busErrorReport, 1'b1);
    $display("store test done");
    report_and_stop;
  end
endmodule

// ==== xlat_mem_model.sv ====
`timescale 1ns/1ps
module xlat_mem_model (
  input  wire logic [2:0] faultSel,
  output logic            xlatRefill,
  output logic            xlatInvalid,
  output logic            xlatModify,
  output logic            busError
);
  // Faults only when a scenario commands one
  assign xlatRefill = faultSel == 3'h1;
  assign xlatInvalid = faultSel == 3'h2;
  assign xlatModify = faultSel == 3'h3;
  assign busError = faultSel == 3'h4;
endmodule
